// ==== include/ccs_pkg.sv ====
//****************************************************************************
// Package: constants for the transmit clock select control block
//****************************************************************************
// Holds register offsets, field positions, reset values and timing counts.
// Assumes an APB master with 12-bit byte addresses and 32-bit data.
//
// Functional notes
// RL1: A zero-to-one change of violation_inject inserts exactly one line code violation.
// RL2: line_standard_select zero runs E1, one runs T1; resets to zero.
// RL3: Sync bit aligns every transmit frame to the 8kHz PLL reference; resets zero.
// RL4: Sync bit in the first channel's register acts for all eight channels.
// RL5: 8kHz alignment applies only while the PLL is the selected timing source.
// RL6: Fallback enable swaps line clock for PLL while recovery lost; resets one.
// RL7: Clock-loss status is detected only while fallback enable is set.
// RL8: Source 00/11 line clock, 01 external pin input, 10 PLL; pin output otherwise.
// RL9: Every read-write bit, reserved ones included, reads back as last written.
package ccs_pkg;

    //************************************************************************
    // Geometry
    //************************************************************************
    localparam int NUM_CH = 8;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CSR_W = 8;

    //************************************************************************
    // Register byte offsets
    //************************************************************************
    localparam logic [ADDR_W-1:0] CSR_BASE = 12'h100;
    localparam logic [ADDR_W-1:0] CSR_LAST = 12'h11C;
    localparam logic [ADDR_W-1:0] INT_STATUS_ADDR = 12'h200;
    localparam logic [ADDR_W-1:0] INT_ENABLE_ADDR = 12'h204;
    localparam logic [ADDR_W-1:0] INT_CLEAR_ADDR = 12'h208;
    localparam logic [ADDR_W-1:0] TIMING_STATE_ADDR = 12'h20C;

    //************************************************************************
    // Channel clock select fields and reset value
    //************************************************************************
    localparam int SRC_LSB = 0;
    localparam int SRC_MSB = 1;
    localparam int FALLBACK_BIT = 4;
    localparam int SYNC_BIT = 5;
    localparam int STD_BIT = 6;
    localparam int INJECT_BIT = 7;
    localparam logic [CSR_W-1:0] CSR_RESET = 8'h11;

    // Timing source encodings
    localparam logic [1:0] SRC_LINE = 2'h0;
    localparam logic [1:0] SRC_EXT = 2'h1;
    localparam logic [1:0] SRC_PLL = 2'h2;
    localparam logic [1:0] SRC_LINE_ALT = 2'h3;

    //************************************************************************
    // Timing
    //************************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int FRAME_PERIOD_NS = 125000;
    localparam int FRAME_CYCLES = FRAME_PERIOD_NS / CLK_PERIOD_NS;
    localparam int FRAME_CNT_W = 12;
    localparam logic [FRAME_CNT_W-1:0] FRAME_LAST = FRAME_CNT_W'(FRAME_CYCLES - 1);

    // Fallback state of one channel
    typedef enum logic {
        FB_NORMAL,
        FB_ON_PLL
    } ccs_fb_state_t;

endpackage

// ==== hw/ccs_chan_ctl.sv ====
// Per-channel transmit timing control: source choice, fallback, LCV, alignment.
// Assumes its register value and line status are synchronous to core_clk.
`timescale 1ns/1ps
module ccs_chan_ctl
    import ccs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [CSR_W-1:0] csrVal,
    input wire logic syncAllEn,
    input wire logic frameTick,
    input wire logic clkLost,
    output logic [1:0] txTimingSel,
    output logic serialClkOe,
    output logic t1Mode,
    output logic lcvPulse,
    output logic alignPulse,
    output logic lossEvent,
    output logic onFallback
);

    ccs_fb_state_t fbState_r;
    ccs_fb_state_t fbState_nxt;
    logic injectPrev_r;
    logic lostPrev_r;
    logic lineSel;
    logic fallbackEn;

    assign lineSel = (csrVal[SRC_MSB:SRC_LSB] == SRC_LINE) ||
                     (csrVal[SRC_MSB:SRC_LSB] == SRC_LINE_ALT); // [RL8]
    assign fallbackEn = csrVal[FALLBACK_BIT];

    // Fallback state: leave the line clock while recovery is lost
    always_comb begin
        fbState_nxt = fbState_r;
        unique case (fbState_r)
            FB_NORMAL: begin
                if (lineSel && fallbackEn && clkLost) begin
                    fbState_nxt = FB_ON_PLL; // [RL6]
                end
            end
            FB_ON_PLL: begin
                if (!clkLost || !lineSel || !fallbackEn) begin
                    fbState_nxt = FB_NORMAL; // [RL6]
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fbState_r <= FB_NORMAL;
        end else begin
            fbState_r <= fbState_nxt;
        end
    end

    // Effective source and pin direction
    always_ff @(posedge core_clk) begin
        if (rst) begin
            txTimingSel <= SRC_EXT;
            serialClkOe <= 1'b0;
            t1Mode <= 1'b0;
        end else begin
            if (!lineSel) begin
                txTimingSel <= csrVal[SRC_MSB:SRC_LSB]; // [RL8]
            end else if (fbState_nxt == FB_ON_PLL) begin
                txTimingSel <= SRC_PLL; // [RL6]
            end else begin
                txTimingSel <= SRC_LINE; // [RL8]
            end
            serialClkOe <= (csrVal[SRC_MSB:SRC_LSB] != SRC_EXT); // [RL8]
            t1Mode <= csrVal[STD_BIT]; // [RL2]
        end
    end

    // Single violation on a rising inject bit only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            injectPrev_r <= 1'b0;
            lcvPulse <= 1'b0;
        end else begin
            injectPrev_r <= csrVal[INJECT_BIT];
            lcvPulse <= csrVal[INJECT_BIT] && !injectPrev_r; // [RL1]
        end
    end

    // Frame alignment only when the PLL is the configured source
    always_ff @(posedge core_clk) begin
        if (rst) begin
            alignPulse <= 1'b0;
        end else begin
            alignPulse <= frameTick && syncAllEn &&
                          (csrVal[SRC_MSB:SRC_LSB] == SRC_PLL); // [RL3] [RL5]
        end
    end

    // Loss event detected only while fallback is enabled
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lostPrev_r <= 1'b0;
            lossEvent <= 1'b0;
        end else begin
            lostPrev_r <= clkLost;
            lossEvent <= clkLost && !lostPrev_r && fallbackEn; // [RL7]
        end
    end

    assign onFallback = (fbState_r == FB_ON_PLL);

endmodule // ccs_chan_ctl

// ==== hw/ccs_clock_select.sv ====
// Eight-channel transmit clock select block with APB register access.
// Assumes an APB master on core_clk and line status inputs synchronous to it.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module ccs_clock_select
    import ccs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_CH-1:0] clkRecoveryLost,
    output logic [2*NUM_CH-1:0] txTimingSel,
    output logic [NUM_CH-1:0] txSerialClockPinOe,
    output logic [NUM_CH-1:0] lineStandardT1,
    output logic [NUM_CH-1:0] lineTxPairViolation,
    output logic [NUM_CH-1:0] txFrameAlign,
    output logic irq
);

    //************************************************************************
    // Declarations
    //************************************************************************
    logic [CSR_W-1:0] chanCsr_r [NUM_CH];
    logic [NUM_CH-1:0] intStatus_r;
    logic [NUM_CH-1:0] intEnable_r;
    logic [NUM_CH-1:0] lossEvent;
    logic [NUM_CH-1:0] onFallback;
    logic [FRAME_CNT_W-1:0] frameCnt_r;
    logic frameTick;
    logic setupPhase;
    logic accessWrite;
    logic csrHit;
    logic [2:0] csrIdx;
    logic knownAddr;
    logic [NUM_CH-1:0] clearMask;
    logic [DATA_W-1:0] readValue;

    //************************************************************************
    // APB decode
    //************************************************************************
    // Setup marks the cycle before access; writes land at the access edge
    assign setupPhase = psel && !penable;
    assign accessWrite = psel && penable && pwrite && !pslverr;
    assign csrHit = (paddr >= CSR_BASE) && (paddr <= CSR_LAST) && (paddr[1:0] == 2'h0);
    assign csrIdx = paddr[4:2];

    // Known addresses of the map
    always_comb begin
        knownAddr = csrHit;
        if (paddr == INT_STATUS_ADDR || paddr == INT_ENABLE_ADDR ||
            paddr == INT_CLEAR_ADDR || paddr == TIMING_STATE_ADDR) begin
            knownAddr = 1'b1;
        end
    end

    // Zero wait states
    assign pready = psel && penable;

    //************************************************************************
    // Read data and error response
    //************************************************************************
    // Read value chosen from the address
    always_comb begin
        readValue = 32'h0000_0000;
        if (csrHit) begin
            readValue = {24'h00_0000, chanCsr_r[csrIdx]}; // [RL9]
        end else if (paddr == INT_STATUS_ADDR) begin
            readValue = {24'h00_0000, intStatus_r};
        end else if (paddr == INT_ENABLE_ADDR) begin
            readValue = {24'h00_0000, intEnable_r};
        end else if (paddr == TIMING_STATE_ADDR) begin
            readValue = {16'h0000, clkRecoveryLost, onFallback};
        end
    end

    // Response captured in setup, held through the access phase
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            prdata <= pwrite ? 32'h0000_0000 : readValue;
            pslverr <= !knownAddr || (!pwrite && paddr == INT_CLEAR_ADDR);
        end
    end

    //************************************************************************
    // Channel clock select registers
    //************************************************************************
    // Per-channel register with byte-lane 0 strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                chanCsr_r[i] <= CSR_RESET; // [RL2] [RL3] [RL6]
            end
        end else if (accessWrite && csrHit && pstrb[0]) begin
            chanCsr_r[csrIdx] <= pwdata[CSR_W-1:0]; // [RL9]
        end
    end

    //************************************************************************
    // Interrupt registers
    //************************************************************************
    // Enable register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            intEnable_r <= 8'h00;
        end else if (accessWrite && paddr == INT_ENABLE_ADDR && pstrb[0]) begin
            intEnable_r <= pwdata[NUM_CH-1:0];
        end
    end

    // Write-one-to-clear mask, only on the access edge
    assign clearMask = (accessWrite && paddr == INT_CLEAR_ADDR && pstrb[0]) ?
                       pwdata[NUM_CH-1:0] : 8'h00;

    // Sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            intStatus_r <= 8'h00;
        end else begin
            intStatus_r <= (intStatus_r & ~clearMask) | lossEvent; // [RL7]
        end
    end

    // Level interrupt
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |((intStatus_r & ~clearMask | lossEvent) & intEnable_r);
        end
    end

    //************************************************************************
    // 8kHz frame reference from the PLL-derived clock
    //************************************************************************
    // One-cycle tick every 125 us
    always_ff @(posedge core_clk) begin
        if (rst) begin
            frameCnt_r <= '0;
        end else if (frameCnt_r == FRAME_LAST) begin
            frameCnt_r <= '0;
        end else begin
            frameCnt_r <= frameCnt_r + 12'h001;
        end
    end

    assign frameTick = (frameCnt_r == FRAME_LAST); // [RL3]

    //************************************************************************
    // Channels
    //************************************************************************
    // Channel 0 sync bit governs all channels
    generate
        for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
            ccs_chan_ctl u_chan (
                .core_clk(core_clk),
                .rst(rst),
                .csrVal(chanCsr_r[ch]),
                .syncAllEn(chanCsr_r[0][SYNC_BIT]), // [RL4]
                .frameTick(frameTick),
                .clkLost(clkRecoveryLost[ch]),
                .txTimingSel(txTimingSel[2*ch+1:2*ch]),
                .serialClkOe(txSerialClockPinOe[ch]),
                .t1Mode(lineStandardT1[ch]),
                .lcvPulse(lineTxPairViolation[ch]),
                .alignPulse(txFrameAlign[ch]),
                .lossEvent(lossEvent[ch]),
                .onFallback(onFallback[ch])
            );
        end
    endgenerate

endmodule // ccs_clock_select

// ==== tb/ccs_liu_model.sv ====
// Line interface model: reports loss of clock recovery per channel.
// Assumes loss requests come from the bench on core_clk.
`timescale 1ns/1ps
module ccs_liu_model #(
    parameter int LAT = 2
) (
    input wire logic core_clk,
    input wire logic [7:0] lossReq,
    output logic [7:0] clkRecoveryLost
);
    logic [7:0] pipe_r [LAT];
    // Loss status trails the request by LAT edges, as a slow recovery loop
    always_ff @(posedge core_clk) begin
        pipe_r[0] <= lossReq;
        for (int i = 1; i < LAT; i++) begin
            pipe_r[i] <= pipe_r[i-1];
        end
    end
    assign clkRecoveryLost = pipe_r[LAT-1];
endmodule // ccs_liu_model

// ==== tb/ccs_clock_select_checker.sv ====
// Checker: APB answer and channel output relations of the clock select block.
// Assumes it is bound to ccs_clock_select and sees only its ports.
`timescale 1ns/1ps
module ccs_clock_select_checker
    import ccs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic pready,
    input wire logic [2*NUM_CH-1:0] txTimingSel,
    input wire logic [NUM_CH-1:0] txSerialClockPinOe,
    input wire logic [NUM_CH-1:0] lineStandardT1,
    input wire logic [NUM_CH-1:0] lineTxPairViolation,
    input wire logic [NUM_CH-1:0] txFrameAlign
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Quiet stretch after an alignment pulse
    sequence s_alignGap;
        !txFrameAlign[0] [*8];
    endsequence
    sequence s_wr0;
        psel && penable && pwrite && paddr == CSR_BASE;
    endsequence
    property p_rdy; (psel && penable) == pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready mismatch");
    property p_injOne; lineTxPairViolation[0] |=> !lineTxPairViolation[0]; endproperty
    a_injOne: assert property (p_injOne) else $error("violation too long");
    property p_injCause;
        $rose(lineTxPairViolation[0]) |->
            $past(psel && penable && pwrite && paddr == CSR_BASE && pwdata[7], 2);
    endproperty
    a_injCause: assert property (p_injCause) else $error("violation uncaused");
    property p_std;
        $changed(lineStandardT1[0]) |-> $past(psel && penable && pwrite && paddr == CSR_BASE, 2);
    endproperty
    a_std: assert property (p_std) else $error("standard changed alone");
    property p_oe; txSerialClockPinOe[0] == (txTimingSel[1:0] != 2'h1); endproperty
    a_oe: assert property (p_oe) else $error("pin direction wrong");
    property p_no3; txTimingSel[1:0] != 2'h3; endproperty
    a_no3: assert property (p_no3) else $error("bad timing code");
    property p_alignSrc; txFrameAlign[0] |-> txTimingSel[1:0] == 2'h2; endproperty
    a_alignSrc: assert property (p_alignSrc) else $error("align off PLL");
    property p_alignGap; txFrameAlign[0] |=> s_alignGap; endproperty
    a_alignGap: assert property (p_alignGap) else $error("align too often");
    cover property (s_wr0);
endmodule // ccs_clock_select_checker

bind ccs_clock_select ccs_clock_select_checker u_chk (.core_clk(core_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .txTimingSel(txTimingSel), .txSerialClockPinOe(txSerialClockPinOe),
    .lineStandardT1(lineStandardT1), .lineTxPairViolation(lineTxPairViolation),
    .txFrameAlign(txFrameAlign));

// ==== tb/tx_clock_select_control_tb.sv ====
// Testbench: APB scenarios for the clock select block and its line model.
// Assumes a 20 MHz core_clk and synchronous active-high reset.
`timescale 1ns/1ps
module tx_clock_select_control_tb
    import ccs_pkg::*;
;
    logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0] pstrb = 0;
    logic [7:0] lossReq = 0, lost, oe, t1, viol, algn;
    logic [15:0] sel;
    logic er;
    int err_total = 0, checks_done = 0, c;
    ccs_clock_select DUT (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .clkRecoveryLost(lost), .txTimingSel(sel),
        .txSerialClockPinOe(oe), .lineStandardT1(t1), .lineTxPairViolation(viol),
        .txFrameAlign(algn), .irq(irq));
    ccs_liu_model #(.LAT(2)) u_liu (.core_clk(core_clk), .lossReq(lossReq),
        .clkRecoveryLost(lost));
    // Clock
    initial forever #25 core_clk = ~core_clk;
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer, waiting a bounded time for pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= 4'hF;
        @(posedge core_clk);
        penable <= 1;
        do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0;
        if (pready !== 1'b1) begin err_total++; end_of_test(); end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic xe);
        apb(0, a, 0); chk(rd, exp); chk(er, xe);
    endtask
    task automatic gap(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Count pulses of one channel over a window
    task automatic pulses(input int n, input int ch, input logic al);
        c = 0;
        repeat (n) begin gap(1); c += al ? algn[ch] : viol[ch]; end
    endtask
    task automatic t_reset();
        rdc(CSR_BASE, 32'h11, 0);
        chk(t1, 8'h00); chk(sel, 16'h5555);
        rdc(12'h300, 0, 1);
    endtask
    task automatic t_rw();
        logic [1:0] m [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
        apb(1, CSR_BASE + 12, 32'h4E); gap(3);
        rdc(CSR_BASE + 12, 32'h4E, 0);
        chk(t1[3], 1);
        for (int s = 0; s < 4; s++) begin
            apb(1, CSR_BASE + 12, s); gap(3);
            chk(sel[7:6], m[s]); chk(oe[3], s != 1);
        end
        chk(t1[3], 0);
    endtask
    task automatic t_inject();
        apb(1, CSR_BASE, 32'h91); pulses(6, 0, 0); chk(c, 1);
        // Inject held high while the standard bit flips: no new violation
        apb(1, CSR_BASE, 32'hD1); pulses(6, 0, 0); chk(c, 0);
        chk(t1[0], 1);
        apb(1, CSR_BASE, 32'h11); pulses(6, 0, 0); chk(c, 0);
        chk(t1[0], 0);
    endtask
    task automatic t_fallback();
        apb(1, CSR_BASE + 4, 32'h10); gap(3);
        lossReq <= 8'h02; gap(5);
        chk(sel[3:2], 2'h2); chk(irq, 0);
        // Live loss and fallback flags of channel 1
        rdc(TIMING_STATE_ADDR, 32'h0202, 0);
        rdc(INT_STATUS_ADDR, 32'h02, 0);
        apb(1, INT_ENABLE_ADDR, 32'h02); gap(2); chk(irq, 1);
        rdc(INT_ENABLE_ADDR, 32'h02, 0);
        apb(1, INT_CLEAR_ADDR, 32'h02); gap(2); chk(irq, 0);
        // Clear register is write-only: a read is refused
        rdc(INT_CLEAR_ADDR, 0, 1);
        lossReq <= 0; gap(5); chk(sel[3:2], 2'h0);
        apb(1, CSR_BASE + 4, 32'h00); gap(3);
        lossReq <= 8'h02; gap(5); chk(sel[3:2], 2'h0);
        rdc(INT_STATUS_ADDR, 0, 0);
        lossReq <= 0;
    endtask
    task automatic t_align();
        apb(1, CSR_BASE + 8, 32'h02); apb(1, CSR_BASE + 16, 32'h00);
        apb(1, CSR_BASE, 32'h32); gap(3);
        pulses(FRAME_CYCLES, 2, 1); chk(c, 1);
        pulses(FRAME_CYCLES, 4, 1); chk(c, 0);
        // Sync bit in channel 2's own copy must not enable alignment
        apb(1, CSR_BASE, 32'h12); apb(1, CSR_BASE + 8, 32'h22); gap(3);
        pulses(FRAME_CYCLES, 2, 1); chk(c, 0);
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 0;
        t_reset();
        t_rw();
        t_inject();
        t_fallback();
        t_align();
        end_of_test();
    end
endmodule // tx_clock_select_control_tb
